// >>> logic/dac_upd_ctrl.sv
`timescale 1ns/1ns
`include "dac_upd_cfg.svh"
// Notes on behaviour
// - write-input with strobe low updates input and output on 24th data clock
// - write-input with strobe high touches input only; later strobe fall copies
// - mask command ignores address, loads mask from low four data bits
// - mask bit 3..0 belong to channels D, C, B, A
// - mask is zero after reset
// - masked channel ignores strobe falling edges, but not a strobe held low
// - strobe falling edge copies input to output on unmasked channels
// - strobe held low makes write-input ignore the mask
// - update command copies input to output, input unchanged
// - write-and-update loads input and output regardless of strobe
// - clear pin low clears outputs to zero or midscale per select pin
// - no output updates while clear low; cleared value kept afterwards
// - software reset returns registers and outputs to power-on code
// - strobe activity during power-on reset is ignored
// - clear low at power-up postpones initialisation until released
// - power-up code zero or midscale per select pin, held until written
// - frame: command nibble, address nibble, sixteen data bits
module dac_upd_ctrl
    import dac_upd_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // serial link pins, data phase gate from the protocol engine
    input wire logic scl,
    input wire logic sda,
    input wire logic frame_gate,
    // control pins
    input wire logic load_strobe_n,
    input wire logic clear_n,
    input wire logic clear_level_select,
    // converter codes
    output logic [15:0] dac_code_a,
    output logic [15:0] dac_code_b,
    output logic [15:0] dac_code_c,
    output logic [15:0] dac_code_d,
    output logic ready
);

    ctl_s q, d;
    logic scl_s, sda_s, gate_s, load_strobe_n_s, clr_s, sel_s;
    logic [3:0] in_we, out_we;
    bank_t in_wd, out_wd, in_q, out_q;
    logic scl_rise, load_strobe_n_fall, exec;
    logic [23:0] word;
    logic [3:0] cmd, addr;
    logic [15:0] live_code;

    // replicate one code to every channel
    function automatic bank_t fill(input logic [15:0] code);
        bank_t b;
        for (int k = 0; k < 4; k++)
            b[k] = code;
        return b;
    endfunction

    // place one code on the addressed channels, the others keep their base words
    function automatic bank_t merge(input bank_t base, input logic [3:0] sel, input logic [15:0] code);
        bank_t b;
        b = base;
        for (int k = 0; k < 4; k++)
            if (sel[k])
                b[k] = code;
        return b;
    endfunction

    // every pin passes two flops before use
    // a pin change is seen one to two clocks late, so link and strobe levels must last several clocks
    sync2 #(.W(6)) u_sync
    (
        .clk(clk),
        .rst(rst),
        .async_in({scl, sda, frame_gate, load_strobe_n, clear_n, clear_level_select}),
        .sync_out({scl_s, sda_s, gate_s, load_strobe_n_s, clr_s, sel_s})
    );

    // input registers, one word per channel
    chan_bank u_in
    (
        .clk(clk),
        .rst(rst),
        .wr_en(in_we),
        .wr_data(in_wd),
        .rd_q(in_q)
    );

    // output registers, one word per channel
    chan_bank u_out
    (
        .clk(clk),
        .rst(rst),
        .wr_en(out_we),
        .wr_data(out_wd),
        .rd_q(out_q)
    );

    // edge detection works on the synchronised copies only
    assign scl_rise = scl_s && !q.scl_prev;
    assign load_strobe_n_fall = q.load_strobe_n_prev && !load_strobe_n_s;
    assign word = {q.shift, sda_s};
    assign cmd = word[`CMD_TOP:`CMD_BOTTOM];
    assign addr = word[`ADDR_TOP:`ADDR_BOTTOM];
    assign exec = scl_rise && gate_s && (q.slot == `LAST_DATA_SLOT);
    assign live_code = sel_s ? `CODE_MID : `CODE_ZERO;

    // next state, bank write enables and bank write data
    always_comb
    begin
        d = q;
        in_we = 4'h0;
        out_we = 4'h0;
        in_wd = fill(word[`DATA_TOP:0]);
        out_wd = in_q;
        d.scl_prev = scl_s;
        d.load_strobe_n_prev = load_strobe_n_s;

        // bit capture; ack clocks carry no data, acks come from the protocol engine
        if (!gate_s)
            d.slot = 5'h00;
        else if (scl_rise)
        begin
            if (q.slot != `ACK_SLOT_0 && q.slot != `ACK_SLOT_1 && q.slot != `SLOT_MAX)
                d.shift = word[22:0];
            if (q.slot != `SLOT_MAX)
                d.slot = q.slot + 5'h01;
        end

        unique case (q.st)
            ST_INIT:
            begin
                // strobe edges are not acted on here
                d.por_code = live_code;
                if (clr_s)
                begin
                    in_we = 4'hf;
                    out_we = 4'hf;
                    in_wd = fill(live_code);
                    out_wd = fill(live_code);
                    d.st = ST_RUN;
                end
            end
            ST_CLEAR:
            begin
                // outputs pinned at the clear code, frames and strobe have no effect
                out_we = 4'hf;
                out_wd = fill(live_code);
                if (clr_s)
                    d.st = ST_RUN;
            end
            ST_RUN:
            begin
                if (!clr_s)
                begin
                    d.st = ST_CLEAR;
                    in_we = 4'hf;
                    out_we = 4'hf;
                    in_wd = fill(live_code);
                    out_wd = fill(live_code);
                end
                else
                begin
                    // unmasked strobe fall copies input to output
                    if (load_strobe_n_fall)
                        out_we = ~q.mask;
                    if (exec)
                    begin
                        if (cmd == `CMD_WRITE_IN)
                        begin
                            in_we = addr;
                            if (!load_strobe_n_s)
                            begin
                                // strobe tied low: mask plays no part
                                out_wd = merge(out_wd, addr, word[`DATA_TOP:0]);
                                out_we = out_we | addr;
                            end
                        end
                        else if (cmd == `CMD_UPDATE)
                            out_we = out_we | addr;
                        else if (cmd == `CMD_WRITE_UPD)
                        begin
                            in_we = addr;
                            // command data wins over a strobe copy landing in the same clock
                            out_wd = merge(out_wd, addr, word[`DATA_TOP:0]);
                            out_we = out_we | addr;
                        end
                        else if (cmd == `CMD_MASK)
                            d.mask = word[`MASK_TOP:0];
                        else if (cmd == `CMD_SOFT_RST)
                        begin
                            d.mask = `MASK_RESET;
                            in_we = 4'hf;
                            out_we = 4'hf;
                            in_wd = fill(q.por_code);
                            out_wd = fill(q.por_code);
                        end
                    end
                end
            end
            default:
                d.st = ST_INIT;
        endcase

        // ready has its own flop: state bit 0 is high in both running and clearing, so no single bit marks running
        d.rdy = (d.st == ST_RUN);
    end

    // single register for all control state
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            q.st <= ST_INIT;
            q.mask <= `MASK_RESET;
            q.slot <= 5'h00;
            q.shift <= 23'h000000;
            q.por_code <= `CODE_ZERO;
            q.scl_prev <= 1'b0;
            q.load_strobe_n_prev <= 1'b0;
            q.rdy <= 1'b0;
        end
        else
            q <= d;
    end

    // outputs come straight from the bank flops and the ready flop
    assign dac_code_a = out_q[0];
    assign dac_code_b = out_q[1];
    assign dac_code_c = out_q[2];
    assign dac_code_d = out_q[3];
    assign ready = q.rdy;

    // checks; where the rules treat the four channels alike, one channel stands for all
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    logic run_now;
    assign run_now = (q.st == ST_RUN) && clr_s;

    // power-on, initialisation and the ready flag
    mask_after_reset_a: assert property ($fell(rst) |-> q.mask == `MASK_RESET && !ready)
        else $error("mask not zero after reset");
    init_wait_a: assert property (q.st == ST_INIT && !clr_s |=> q.st == ST_INIT && $stable(out_q))
        else $error("initialised while clear low");
    init_code_a: assert property (q.st == ST_INIT && clr_s |=> out_q[0] == $past(live_code) && ready)
        else $error("power-on code not applied");
    not_ready_a: assert property (q.st == ST_INIT || q.st == ST_CLEAR |-> !ready)
        else $error("ready high while not running");

    // mask register; the mask only moves on its own command or a software reset
    mask_load_a: assert property (run_now && exec && cmd == `CMD_MASK |=> q.mask == $past(word[3:0]))
        else $error("mask not loaded from low data bits");
    mask_keep_a: assert property (!(run_now && exec && (cmd == `CMD_MASK || cmd == `CMD_SOFT_RST))
        |=> $stable(q.mask))
        else $error("mask changed without a command");

    // strobe; the bench masks channels B and D, channel A stays open
    masked_strobe_a: assert property (run_now && load_strobe_n_fall && q.mask[1] && !exec
        |=> $stable(out_q[1]))
        else $error("masked channel followed the strobe");
    strobe_copy_a: assert property (run_now && load_strobe_n_fall && !q.mask[0] |=> out_q[0] == $past(in_q[0]))
        else $error("strobe fall did not copy input");
    strobe_low_mask_a: assert property (run_now && exec && cmd == `CMD_WRITE_IN && !load_strobe_n_s && addr[3]
        && q.mask[3] |=> out_q[3] == $past(word[15:0]))
        else $error("strobe held low did not override the mask");

    // commands
    write_low_a: assert property (run_now && exec && cmd == `CMD_WRITE_IN && !load_strobe_n_s && addr[0]
        |=> out_q[0] == $past(word[15:0]) && in_q[0] == $past(word[15:0]))
        else $error("write with strobe low missed output");
    write_high_a: assert property (run_now && exec && cmd == `CMD_WRITE_IN && load_strobe_n_s && !load_strobe_n_fall
        |=> $stable(out_q))
        else $error("write with strobe high changed output");
    update_cmd_a: assert property (run_now && exec && cmd == `CMD_UPDATE && addr[3]
        |=> out_q[3] == $past(in_q[3]) && $stable(in_q))
        else $error("update command wrong");
    write_update_a: assert property (run_now && exec && cmd == `CMD_WRITE_UPD && addr[0]
        |=> out_q[0] == $past(word[15:0]) && in_q[0] == $past(word[15:0]))
        else $error("write and update wrong");
    soft_reset_a: assert property (run_now && exec && cmd == `CMD_SOFT_RST
        |=> out_q == fill($past(q.por_code)) && q.mask == `MASK_RESET)
        else $error("software reset wrong");

    // clear pin
    clear_entry_a: assert property (q.st == ST_RUN && !clr_s |=> out_q[0] == $past(live_code))
        else $error("clear code not applied");
    clear_inputs_a: assert property (q.st == ST_RUN && !clr_s |=> in_q == fill($past(live_code)))
        else $error("clear did not reach the input registers");
    clear_hold_a: assert property (q.st == ST_CLEAR && !clr_s |=> q.st == ST_CLEAR && $stable(out_q))
        else $error("output moved while clear low");
    clear_release_a: assert property (q.st == ST_CLEAR && clr_s |=> $stable(out_q) && ready)
        else $error("output moved on clear release");

    // scenario coverage
    cov_strobe_c: cover property (run_now && load_strobe_n_fall && q.mask != 4'h0);
    cov_write_c: cover property (run_now && exec && cmd == `CMD_WRITE_IN);
    cov_clear_c: cover property (q.st == ST_CLEAR ##1 q.st == ST_RUN);
    cov_mask_c: cover property (run_now && exec && cmd == `CMD_MASK);
    cov_soft_rst_c: cover property (run_now && exec && cmd == `CMD_SOFT_RST);

endmodule

// >>> logic/dac_upd_cfg.svh
`ifndef DAC_UPD_CFG_SVH
`define DAC_UPD_CFG_SVH

// command field values, top nibble of the 24-bit frame
`define CMD_WRITE_IN 4'h1
`define CMD_UPDATE 4'h2
`define CMD_WRITE_UPD 4'h3
`define CMD_MASK 4'h5
`define CMD_SOFT_RST 4'h6

// frame layout
`define FRAME_BITS 24
`define CMD_TOP 23
`define CMD_BOTTOM 20
`define ADDR_TOP 19
`define ADDR_BOTTOM 16
`define DATA_TOP 15
`define MASK_TOP 3

// serial clock positions inside the data phase (9 clocks per byte, 9th is ack)
`define ACK_SLOT_0 5'h08
`define ACK_SLOT_1 5'h11
`define LAST_DATA_SLOT 5'h19
`define SLOT_MAX 5'h1a

// clear codes and reset values
`define CODE_ZERO 16'h0000
`define CODE_MID 16'h8000
`define MASK_RESET 4'h0

// timing
`define CLK_PERIOD_NS 50
`define CLEAR_MIN_NS 30
`define CLEAR_MIN_CYC ((`CLEAR_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// >>> logic/dac_upd_pkg.sv
package dac_upd_pkg;

    // gray sequence: init -> run -> clear -> run
    typedef enum logic [1:0]
    {
        ST_INIT = 2'b00,
        ST_RUN = 2'b01,
        ST_CLEAR = 2'b11
    } upd_state_e;

    typedef logic [3:0][15:0] bank_t;

    typedef struct packed
    {
        upd_state_e st;
        logic [3:0] mask;
        logic [4:0] slot;
        logic [22:0] shift;
        logic [15:0] por_code;
        logic scl_prev;
        logic load_strobe_n_prev;
        logic rdy;
    } ctl_s;

endpackage

// >>> logic/sync2.sv
`timescale 1ns/1ns
module sync2
#(
    parameter int W = 1
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // asynchronous level in, synchronised level out
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);

    logic [W-1:0] meta_q;

    // first stage feeds only the second stage
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            meta_q <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule

// >>> logic/chan_bank.sv
`timescale 1ns/1ns
`include "dac_upd_cfg.svh"
module chan_bank
    import dac_upd_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // per-channel write port
    input wire logic [3:0] wr_en,
    input wire bank_t wr_data,
    // all four words, straight from flops
    output bank_t rd_q
);

    // each channel is an independent 16-bit word so all can load in one edge
    genvar i;
    generate
        for (i = 0; i < 4; i++)
        begin : g_chan
            always_ff @(posedge clk)
            begin
                if (rst)
                    rd_q[i] <= `CODE_ZERO;
                else if (wr_en[i])
                    rd_q[i] <= wr_data[i];
            end
        end
    endgenerate

endmodule

// >>> tb/host_model.sv
`timescale 1ns/1ns
module host_model
(
    // system clock, used only to pace the link
    input wire logic clk,
    // serial pins toward the device
    output logic scl,
    output logic sda,
    output logic frame_gate
);
    // idle bus: pull-ups hold both lines high, link clock stands still
    initial
    begin
        scl = 1'b1;
        sda = 1'b1;
        frame_gate = 1'b0;
    end

    // half of a 400 ns link period
    task automatic half_bit();
        repeat (4) @(negedge clk);
    endtask

    // command byte, then data high byte, then data low byte, each with an ack clock
    task automatic send(input logic [3:0] cmd, input logic [3:0] addr, input logic [15:0] data);
        logic [23:0] frame;
        int bit_ix;
        frame = {cmd, addr, data};
        bit_ix = 23;
        @(negedge clk);
        frame_gate = 1'b1;
        half_bit();
        for (int slot = 0; slot < 27; slot++)
        begin
            scl = 1'b0;
            // ack clocks: host lets go of data, the pull-up wins
            if (slot % 9 == 8)
                sda = 1'b1;
            else
            begin
                sda = frame[bit_ix];
                bit_ix--;
            end
            half_bit();
            scl = 1'b1;
            half_bit();
        end
        sda = 1'b1;
        frame_gate = 1'b0;
        // gap long enough to clear the slot counter and let outputs settle
        repeat (8) @(negedge clk);
    endtask
endmodule

// >>> tb/dac_upd_ctrl_test.sv
`timescale 1ns/1ns
`include "dac_upd_cfg.svh"
module dac_upd_ctrl_test;
    logic clk;
    logic rst;
    logic scl;
    logic sda;
    logic frame_gate;
    logic load_strobe_n;
    logic clear_n;
    logic clear_level_select;
    logic [15:0] code_a;
    logic [15:0] code_b;
    logic [15:0] code_c;
    logic [15:0] code_d;
    logic ready;
    int failures;
    int num_checks;

    // device under test
    dac_upd_ctrl dac_upd_ctrl_inst
    (
        .clk(clk),
        .rst(rst),
        .scl(scl),
        .sda(sda),
        .frame_gate(frame_gate),
        .load_strobe_n(load_strobe_n),
        .clear_n(clear_n),
        .clear_level_select(clear_level_select),
        .dac_code_a(code_a),
        .dac_code_b(code_b),
        .dac_code_c(code_c),
        .dac_code_d(code_d),
        .ready(ready)
    );

    // host side of the serial link
    host_model host_model_inst
    (
        .clk(clk),
        .scl(scl),
        .sda(sda),
        .frame_gate(frame_gate)
    );

    // 20 MHz clock
    initial
    begin
        clk = 1'b0;
    end
    always #25 clk = ~clk;

    task automatic report_and_stop();
        if (failures == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        num_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic check_all(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c, input logic [15:0] d);
        chk16(code_a, a);
        chk16(code_b, b);
        chk16(code_c, c);
        chk16(code_d, d);
    endtask

    // bounded wait, the caller compares ready afterwards
    task automatic wait_ready();
        int n;
        n = 0;
        while (ready !== 1'b1 && n < 100)
        begin
            @(negedge clk);
            n++;
        end
    endtask

    // a strobe fall long enough for the synchroniser to see both levels
    task automatic strobe_pulse();
        @(negedge clk);
        load_strobe_n = 1'b0;
        repeat (4) @(negedge clk);
        load_strobe_n = 1'b1;
        repeat (4) @(negedge clk);
    endtask

    task automatic pulse_reset();
        @(negedge clk);
        rst = 1'b1;
        repeat (6) @(negedge clk);
        rst = 1'b0;
    endtask

    // watchdog, far beyond the dozen frames of the run
    initial
    begin
        repeat (20000) @(posedge clk);
        failures++;
        report_and_stop();
    end

    initial
    begin
        failures = 0;
        num_checks = 0;
        rst = 1'b1;
        load_strobe_n = 1'b1;
        clear_n = 1'b1;
        clear_level_select = 1'b1;
        repeat (6) @(negedge clk);
        rst = 1'b0;
        wait_ready();
        chk1(ready, 1'b1);
        check_all(16'h8000, 16'h8000, 16'h8000, 16'h8000);
        // deferred update through the strobe
        host_model_inst.send(`CMD_WRITE_IN, 4'h1, 16'h1234);
        check_all(16'h8000, 16'h8000, 16'h8000, 16'h8000);
        strobe_pulse();
        check_all(16'h1234, 16'h8000, 16'h8000, 16'h8000);
        // mask B and D, address nibble must not matter
        host_model_inst.send(`CMD_MASK, 4'h5, 16'hfffa);
        host_model_inst.send(`CMD_WRITE_IN, 4'hf, 16'h5555);
        strobe_pulse();
        check_all(16'h5555, 16'h8000, 16'h5555, 16'h8000);
        host_model_inst.send(`CMD_UPDATE, 4'h8, 16'h0000);
        check_all(16'h5555, 16'h8000, 16'h5555, 16'h5555);
        host_model_inst.send(`CMD_WRITE_UPD, 4'h2, 16'h7777);
        check_all(16'h5555, 16'h7777, 16'h5555, 16'h5555);
        // strobe held low: masked channel D still follows the write
        load_strobe_n = 1'b0;
        host_model_inst.send(`CMD_WRITE_IN, 4'h8, 16'h0ddd);
        check_all(16'h5555, 16'h7777, 16'h5555, 16'h0ddd);
        load_strobe_n = 1'b1;
        // clear to zero scale, writes refused while low
        clear_level_select = 1'b0;
        clear_n = 1'b0;
        repeat (4) @(negedge clk);
        check_all(16'h0000, 16'h0000, 16'h0000, 16'h0000);
        chk1(ready, 1'b0);
        host_model_inst.send(`CMD_WRITE_UPD, 4'hf, 16'habcd);
        check_all(16'h0000, 16'h0000, 16'h0000, 16'h0000);
        clear_n = 1'b1;
        repeat (6) @(negedge clk);
        check_all(16'h0000, 16'h0000, 16'h0000, 16'h0000);
        // soft reset returns the power-on code, not the live select level
        host_model_inst.send(`CMD_WRITE_UPD, 4'h1, 16'h4321);
        host_model_inst.send(`CMD_SOFT_RST, 4'h0, 16'h0000);
        check_all(16'h8000, 16'h8000, 16'h8000, 16'h8000);
        host_model_inst.send(`CMD_WRITE_IN, 4'hf, 16'h2468);
        strobe_pulse();
        check_all(16'h2468, 16'h2468, 16'h2468, 16'h2468);
        // power-up with clear held low and the strobe busy
        clear_level_select = 1'b1;
        clear_n = 1'b0;
        pulse_reset();
        strobe_pulse();
        strobe_pulse();
        chk1(ready, 1'b0);
        check_all(16'h0000, 16'h0000, 16'h0000, 16'h0000);
        clear_n = 1'b1;
        wait_ready();
        chk1(ready, 1'b1);
        check_all(16'h8000, 16'h8000, 16'h8000, 16'h8000);
        // power-up at zero scale; soft reset must return that code, not the live select level
        clear_level_select = 1'b0;
        pulse_reset();
        wait_ready();
        chk1(ready, 1'b1);
        host_model_inst.send(`CMD_WRITE_UPD, 4'hf, 16'h1111);
        check_all(16'h1111, 16'h1111, 16'h1111, 16'h1111);
        clear_level_select = 1'b1;
        host_model_inst.send(`CMD_SOFT_RST, 4'h0, 16'h0000);
        check_all(16'h0000, 16'h0000, 16'h0000, 16'h0000);
        report_and_stop();
    end
endmodule
